/* File: src/tdc_defines.svh */
// Register offsets, field positions and reset values for the delay compensation block
`ifndef TDC_DEFINES_SVH
`define TDC_DEFINES_SVH
`define TDC_OFF_CABLE   8'h20
`define TDC_OFF_PENDING 8'h30
`define TDC_DELAY_MSB   15
`define TDC_DELAY_RST   16'h0000
`define TDC_PEND_BIT    0
`define TDC_NS_WRAP     32'h3B9A_CA00
`endif

/* File: src/tdc_pkg.sv */
// Types shared by the delay compensation block
package tdc_pkg;
  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } tdc_time_type;

  typedef struct packed {
    logic         wr;
    logic         rd;
    logic [7:0]   addr;
    logic [31:0]  wdata;
  } tdc_bus_type;

  typedef struct packed {
    logic [15:0]           delay;
    logic                  pend;
    tdc_time_type          stamp;
    logic                  stamp_vld;
    logic [31:0]           rdata;
    logic [2:0]            evt_sync;
  } tdc_state_type;
endpackage

/* File: src/tdc_core.sv */
// Cable delay compensation and pending-event flag of the timestamp unit
`timescale 1ns/1ps
`include "tdc_defines.svh"

module tdc_core (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire tdc_pkg::tdc_bus_type  bus_req,
  output logic [31:0]                bus_rdata,
  input  wire logic                  ts_enable,
  input  wire logic                  evt_in,
  input  wire tdc_pkg::tdc_time_type now_time,
  output tdc_pkg::tdc_time_type      stamp_out,
  output logic                       stamp_vld,
  output logic                       irq_out
);

  // Timing: an event edge is seen two flops after the pin and stamped on
  // the following edge, so stamp_vld trails the rise of evt_in by three clocks.
  // The enable is a same-clock level from the mask logic elsewhere, so it is
  // used as it stands; the event pin is not, hence the synchroniser.
  // Trade-off: the stamp carries the synchroniser latency as a fixed offset,
  // which a user may fold into the programmed cable delay.
  // Helpers below are combinational and hold no state of their own.

  tdc_pkg::tdc_state_type st_r;      // Whole state of the block
  tdc_pkg::tdc_state_type st_nxt;    // Next state
  logic                   edge_seen; // Rising edge of synchronised event
  logic                   capture;   // Qualified capture this cycle
  logic [31:0]            ns_corr;   // Nanoseconds after delay subtraction
  logic                   borrow;    // Correction crossed a second boundary

  // Event line is asynchronous; bit 0 is the first synchroniser stage only
  assign edge_seen = st_r.evt_sync[1] & ~st_r.evt_sync[2];
  assign capture   = edge_seen & ts_enable & ~st_r.pend;

  // Subtract delay with borrow into seconds; delay is below one second
  always_comb
  begin
    // Compare on the full 32-bit nanosecond word
    borrow  = now_time.ns < {16'h0000, st_r.delay};
    ns_corr = now_time.ns - {16'h0000, st_r.delay};
    // Wrap back into the previous second
    if (borrow)
    begin
      ns_corr = ns_corr + `TDC_NS_WRAP;
    end
  end

  // Next state
  always_comb
  begin
    st_nxt           = st_r;
    // Shift the event pin through the synchroniser and edge stage
    st_nxt.evt_sync  = {st_r.evt_sync[1:0], evt_in};
    // Valid is a one-cycle pulse
    st_nxt.stamp_vld = 1'b0;
    // Register writes
    if (bus_req.wr && bus_req.addr == `TDC_OFF_CABLE)
    begin
      // Upper write bits are dropped
      st_nxt.delay = bus_req.wdata[`TDC_DELAY_MSB:0];
    end
    // Writing zero to the flag bit leaves the flag alone
    if (bus_req.wr && bus_req.addr == `TDC_OFF_PENDING && bus_req.wdata[`TDC_PEND_BIT])
    begin
      st_nxt.pend = 1'b0;
    end
    // Capture wins over a clear in the same cycle
    // so the flag it sets survives the clear; an event that meets the clear while the flag is set is lost
    if (capture)
    begin
      // Seconds borrow when the correction crossed zero
      st_nxt.stamp.sec = now_time.sec - {31'h0000_0000, borrow};
      st_nxt.stamp.ns  = ns_corr;
      st_nxt.stamp_vld = 1'b1;
      st_nxt.pend      = 1'b1;
    end
    // Read data registered, reserved bits zero
    st_nxt.rdata = 32'h0000_0000;
    if (bus_req.rd)
    begin
      // Decode only the two offsets of this block
      unique case (bus_req.addr)
        `TDC_OFF_CABLE:   st_nxt.rdata = {16'h0000, st_r.delay};
        `TDC_OFF_PENDING: st_nxt.rdata = {31'h0000_0000, st_r.pend};
        default:          st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Reset clears flag and stamp; delay has its own reset value
      st_r       <= '0;
      st_r.delay <= `TDC_DELAY_RST;
    end
    else
    begin
      // Every register updates on every clock
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flops, except the gated interrupt
  // Interrupt is masked by the enable so a disabled unit stays quiet
  assign bus_rdata = st_r.rdata;
  assign stamp_out = st_r.stamp;
  assign stamp_vld = st_r.stamp_vld;
  assign irq_out   = st_r.pend & ts_enable;

  // No stamp stored while a flag was already pending
  property p_no_cap_pend;
    @(posedge clk_sys) disable iff (!rst_n)
    stamp_vld |-> !$past(st_r.pend);
  endproperty
  a_no_cap_pend: assert property (p_no_cap_pend) else $error("stamp while pending");

  // A stamp always comes with the flag
  property p_vld_sets_pend;
    @(posedge clk_sys) disable iff (!rst_n)
    stamp_vld |-> st_r.pend;
  endproperty
  a_vld_sets_pend: assert property (p_vld_sets_pend) else $error("flag not set with stamp");

  // Enable low means no stamp on the next edge
  property p_enable_blocks;
    @(posedge clk_sys) disable iff (!rst_n)
    !ts_enable |-> ##1 !stamp_vld;
  endproperty
  a_enable_blocks: assert property (p_enable_blocks) else $error("stamp while disabled");

  // Interrupt line quiet while disabled
  property p_irq_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    !ts_enable |-> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

  // Writing one clears the flag unless a capture meets it
  property p_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == `TDC_OFF_PENDING && bus_req.wdata[0] && !capture |=> !st_r.pend;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  // Writing zero to the flag bit keeps a pending flag
  property p_wr0_keeps;
    @(posedge clk_sys) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == `TDC_OFF_PENDING && !bus_req.wdata[`TDC_PEND_BIT] && st_r.pend |=> st_r.pend;
  endproperty
  a_wr0_keeps: assert property (p_wr0_keeps) else $error("flag lost on zero write");

  // The flag only falls after a clearing write
  property p_fall_by_write;
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(st_r.pend) |-> $past(bus_req.wr) && $past(bus_req.addr) == `TDC_OFF_PENDING;
  endproperty
  a_fall_by_write: assert property (p_fall_by_write) else $error("flag fell without write");

  // Delay written from the low half of the data
  property p_delay_wr;
    @(posedge clk_sys) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == `TDC_OFF_CABLE |=> st_r.delay == $past(bus_req.wdata[15:0]);
  endproperty
  a_delay_wr: assert property (p_delay_wr) else $error("delay not written");

  // Delay holds unless written
  property p_delay_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !(bus_req.wr && bus_req.addr == `TDC_OFF_CABLE) |=> $stable(st_r.delay);
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay changed unasked");

  // Delay reads back with upper bits zero
  property p_rd_delay;
    @(posedge clk_sys) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == `TDC_OFF_CABLE |=> bus_rdata == {16'h0000, $past(st_r.delay)};
  endproperty
  a_rd_delay: assert property (p_rd_delay) else $error("delay readback wrong");

  // Read data is zero when no read was made
  property p_rd_idle;
    @(posedge clk_sys) disable iff (!rst_n)
    !bus_req.rd |=> bus_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

  // Flag reads in bit zero only
  property p_rd_pend;
    @(posedge clk_sys) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == `TDC_OFF_PENDING |=> bus_rdata == {31'h0, $past(st_r.pend)};
  endproperty
  a_rd_pend: assert property (p_rd_pend) else $error("flag readback wrong");

  // Stamp holds between captures
  property p_stamp_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !capture |=> $stable(stamp_out);
  endproperty
  a_stamp_hold: assert property (p_stamp_hold) else $error("stamp changed without capture");

  // Borrow takes one second off
  property p_borrow_sec;
    @(posedge clk_sys) disable iff (!rst_n)
    capture && borrow |=> stamp_out.sec == $past(now_time.sec) - 32'h0000_0001;
  endproperty
  a_borrow_sec: assert property (p_borrow_sec) else $error("second not borrowed");

  // Nanoseconds corrected by the delay
  property p_correct;
    @(posedge clk_sys) disable iff (!rst_n)
    capture && !borrow |=> stamp_out.ns == $past(now_time.ns) - {16'h0000, $past(st_r.delay)};
  endproperty
  a_correct: assert property (p_correct) else $error("stamp not corrected");

endmodule

/* File: sim/tdc_host.sv */
// Bus master model that drives register strobes into the block
`timescale 1ns/1ps
module tdc_host (
  input  wire logic           clk_sys,
  output tdc_pkg::tdc_bus_type bus_req,
  input  wire logic [31:0]    bus_rdata
);
  initial bus_req = '0;
  // One strobe cycle; read data is taken mid-cycle, away from the edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys) q = bus_rdata;
    @(posedge clk_sys);
  endtask
endmodule

/* File: sim/tdc_core_test.sv */
// Self-checking bench for the delay compensation block
`timescale 1ns/1ps
module tdc_core_test;
  logic clk_sys = 0, rst_n = 0, ts_enable = 1, evt_in = 0, stamp_vld, irq_out, s;
  logic [31:0] bus_rdata, rd;
  tdc_pkg::tdc_bus_type  bus_req;
  tdc_pkg::tdc_time_type now_time = '{32'h0000_0005, 32'h0000_0064};
  tdc_pkg::tdc_time_type stamp_out;
  int n_fail = 0, n_tests = 0;
  // Delay written beside the value read back
  logic [31:0] rows [3][2] = '{'{32'hFFFF_1234, 32'h0000_1234}, '{32'h0000_FFFF, 32'h0000_FFFF},
                               '{32'h0000_001E, 32'h0000_001E}};
  always #50 clk_sys = ~clk_sys;
  tdc_core dut_u (.clk_sys, .rst_n, .bus_req, .bus_rdata, .ts_enable, .evt_in, .now_time, .stamp_out,
                  .stamp_vld, .irq_out);
  tdc_host h (.clk_sys, .bus_req, .bus_rdata);
  task automatic chk(input string n, input logic [63:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Pulse the event and watch for a stamp; the gap lets the edge detector settle
  task automatic ev(output logic seen);
    seen = 0;
    evt_in <= 1;
    repeat (6) @(negedge clk_sys) seen |= stamp_vld;
    @(posedge clk_sys) evt_in <= 0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #200us;
    n_fail++;
    results;
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    chk("in rst", 34'h0, {irq_out, stamp_vld, bus_rdata});
    rst_n <= 1;
    @(posedge clk_sys);
    h.acc(0, 8'h20, 32'h0, rd);
    chk("delay rst", 32'h0, rd);
    foreach (rows[i])
    begin
      h.acc(1, 8'h20, rows[i][0], rd);
      h.acc(0, 8'h20, 32'h0, rd);
      chk("delay", rows[i][1], rd);
    end
    h.acc(0, 8'h44, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ev(s);
    chk("vld", 1'h1, s);
    chk("stamp", {32'h0000_0005, 32'h0000_0046}, stamp_out);
    chk("irq", 1'h1, irq_out);
    h.acc(0, 8'h30, 32'h0, rd);
    chk("pend", 32'h1, rd);
    h.acc(1, 8'h30, 32'h0, rd);
    h.acc(0, 8'h30, 32'h0, rd);
    chk("wr0 keeps", 32'h1, rd);
    ev(s);
    chk("blocked", 1'h0, s);
    h.acc(1, 8'h30, 32'h1, rd);
    chk("clr", 1'h0, irq_out);
    h.acc(0, 8'h30, 32'h0, rd);
    chk("pend clr", 32'h0, rd);
    // Borrow across the second boundary
    now_time <= '{32'h0000_0005, 32'h0000_000A};
    ev(s);
    chk("wrap", {32'h0000_0004, 32'h3B9A_C9EC}, stamp_out);
    h.acc(1, 8'h30, 32'h1, rd);
    ts_enable <= 0;
    ev(s);
    chk("off", 2'h0, {s, irq_out});
    ts_enable <= 1;
    ev(s);
    chk("resume", 1'h1, s);
    rst_n <= 0;
    repeat (2) @(posedge clk_sys);
    chk("mid rst", 34'h0, {irq_out, stamp_vld, bus_rdata});
    rst_n <= 1;
    @(posedge clk_sys);
    h.acc(0, 8'h20, 32'h0, rd);
    chk("rst delay", 32'h0, rd);
    chk("rst irq", 1'h0, irq_out);
    results;
  end
endmodule
